/* File: include/tpp_consts.svh */
// constants for the tlb parity protection block
// How it works
// - the tlb sync command does nothing architecturally.
// - no reference or change history is kept for pages or entries.
// - sixty-four entries, each with forty tag, forty-one data, eight parity bits.
// - four parity bits on tag, two on word 1, two on word 2.
// - search has no multi-hit detection; lowest matching index wins.
// - every entry word write stores freshly computed parity.
// - shadow refills check tag and both data words.
// - search checks only tag parity of the matching entry.
// - read checks parity only of the selected word.
// - a parity error raises machine check; taken when check enable set.
// - readout enable places stored parity into the read result.
// - parity error sets tlb-error and summary flags.
// - taking the check vectors out and clears check enable.
// - with recovery enable, an erroring read that takes the check leaves its result untouched.
// - check enable clear: flags plus imprecise flag, read completes.
// - save address and previous machine state on taking the check.
// - checking searches, checking reads with recovery enable and erroring refills are flushed.
// - parity stored is even parity over each bit group.
// - set inject bits invert the computed parity on writes.
// - parity positions of the write source are ignored.
// - readout enable clear returns zeros in parity positions.
`ifndef TPP_CONSTS_SVH
`define TPP_CONSTS_SVH
`define TPP_ENTRIES   64
`define TPP_IDX_W     6
`define TPP_TAG_W     40
`define TPP_W1_W      26
`define TPP_W2_W      15
`define TPP_PAR_W     8
`define TPP_TAG_GRP   10
`define TPP_W1_GRP    13
`define TPP_PAR_TAG   7:4
`define TPP_PAR_W1    3:2
`define TPP_PAR_W2    1:0
`define TPP_W2_HI     14:8
`define TPP_W2_LO     7:0
`define TPP_OFF_CFGA  8'h00
`define TPP_OFF_CFGB  8'h04
`define TPP_OFF_MSR   8'h08
`define TPP_OFF_MACHINE_CHECK_STATUS_REG  8'h0C
`define TPP_OFF_SAV0  8'h10
`define TPP_OFF_SAV1  8'h14
`define TPP_OFF_PC    8'h18
`define TPP_OFF_GPR   8'h1C
`define TPP_OFF_CMD   8'h20
`define TPP_OFF_DEST  8'h24
`define TPP_OFF_STAT  8'h28
`define TPP_CFGA_RDPAR 0
`define TPP_CFGA_RECOV 1
`define TPP_CFGB_INJ  3:0
`define TPP_MSR_ME    0
`define TPP_MACHINE_CHECK_STATUS_REG_TRANSLATION_PARITY_ERROR_FLAG 0
`define TPP_MACHINE_CHECK_STATUS_REG_MCS  1
`define TPP_MACHINE_CHECK_STATUS_REG_IMPRECISE_CHECK_FLAG 2
`define TPP_CMD_OP    2:0
`define TPP_CMD_WS    5:4
`define TPP_CMD_IDX   13:8
`define TPP_CMD_TID   23:16
`define TPP_WS0       2'h0
`define TPP_WS1       2'h1
`define TPP_WS2       2'h2
`define TPP_G0_HI     31:4
`define TPP_G0_PAR    3:0
`define TPP_G1_HI     31:10
`define TPP_G1_PAR    9:8
`define TPP_G1_LO     3:0
`define TPP_G2_PAR    17:16
`define TPP_G2_DAT    14:0
`define TPP_ST_DONE   0
`define TPP_ST_FLUSH  1
`define TPP_ST_HIT    2
`define TPP_ST_TAKEN  3
`define TPP_ZERO32    32'h00000000
`endif

/* File: include/tpp_pkg.sv */
// types of the tlb parity protection block
package tpp_pkg;
  typedef enum logic [2:0] {
    TPP_OP_SYNC   = 3'h0,
    TPP_OP_WRITE  = 3'h1,
    TPP_OP_READ   = 3'h2,
    TPP_OP_SEARCH = 3'h3,
    TPP_OP_RFL_I  = 3'h4,
    TPP_OP_RFL_D  = 3'h5
  } tpp_op_e;
  typedef enum logic [2:0] {
    TPP_BUS_IDLE  = 3'b001,
    TPP_BUS_RDCAP = 3'b010,
    TPP_BUS_RDOUT = 3'b100
  } tpp_bus_e;
endpackage

/* File: include/tpp_tlb_if.sv */
// interface between command logic and the translation array
`timescale 1ns/1ns
`include "tpp_consts.svh"
interface tpp_tlb_if;
  logic                    we;
  logic [1:0]              wws;
  logic [`TPP_IDX_W-1:0]   widx;
  logic [`TPP_TAG_W-1:0]   wtag;
  logic [`TPP_W1_W-1:0]    ww1;
  logic [`TPP_W2_W-1:0]    ww2;
  logic [`TPP_PAR_W-1:0]   wpar;
  logic [`TPP_IDX_W-1:0]   ridx;
  logic [`TPP_TAG_W-1:0]   rtag;
  logic [`TPP_W1_W-1:0]    rw1;
  logic [`TPP_W2_W-1:0]    rw2;
  logic [`TPP_PAR_W-1:0]   rpar;
  logic [`TPP_TAG_W-1:0]   skey;
  logic                    shit;
  logic [`TPP_IDX_W-1:0]   sidx;
  modport ctl (output we, wws, widx, wtag, ww1, ww2, wpar, ridx, skey,
               input rtag, rw1, rw2, rpar, shit, sidx);
  modport mem (input we, wws, widx, wtag, ww1, ww2, wpar, ridx, skey,
               output rtag, rw1, rw2, rpar, shit, sidx);
endinterface

/* File: src/tpp_par_calc.sv */
// even parity over the protected bit groups of one entry
`timescale 1ns/1ns
`include "tpp_consts.svh"
module tpp_par_calc
(
  input  wire logic [`TPP_TAG_W-1:0] tag,
  input  wire logic [`TPP_W1_W-1:0]  w1,
  input  wire logic [`TPP_W2_W-1:0]  w2,
  output logic      [`TPP_PAR_W-1:0] par
);
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_tag
      assign par[4+g] = ^tag[g*`TPP_TAG_GRP +: `TPP_TAG_GRP];
    end
    for (g = 0; g < 2; g++)
    begin : g_w1
      assign par[2+g] = ^w1[g*`TPP_W1_GRP +: `TPP_W1_GRP];
    end
  endgenerate
  assign par[1] = ^w2[`TPP_W2_HI];
  assign par[0] = ^w2[`TPP_W2_LO];
endmodule

/* File: src/tpp_tlb_mem.sv */
// sixty-four entry translation array with word writes, index read and tag search
`timescale 1ns/1ns
`include "tpp_consts.svh"
module tpp_tlb_mem
(
  input  wire logic hclk,
  input  wire logic hresetn,
  tpp_tlb_if.mem    port
);
  logic [`TPP_TAG_W-1:0] tag_ff [`TPP_ENTRIES];
  logic [`TPP_W1_W-1:0]  w1_ff  [`TPP_ENTRIES];
  logic [`TPP_W2_W-1:0]  w2_ff  [`TPP_ENTRIES];
  logic [`TPP_PAR_W-1:0] par_ff [`TPP_ENTRIES];
  logic [`TPP_ENTRIES-1:0] match;

  genvar e;
  generate
    for (e = 0; e < `TPP_ENTRIES; e++)
    begin : g_ent
      // only words and parity are held; nothing records use or change
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          tag_ff[e] <= '0;
          w1_ff[e]  <= '0;
          w2_ff[e]  <= '0;
          par_ff[e] <= '0;
        end
        else if (port.we && port.widx == `TPP_IDX_W'(e))
        begin
          if (port.wws == `TPP_WS0)
          begin
            tag_ff[e]              <= port.wtag;
            par_ff[e][`TPP_PAR_TAG] <= port.wpar[`TPP_PAR_TAG];
          end
          else if (port.wws == `TPP_WS1)
          begin
            w1_ff[e]               <= port.ww1;
            par_ff[e][`TPP_PAR_W1]  <= port.wpar[`TPP_PAR_W1];
          end
          else if (port.wws == `TPP_WS2)
          begin
            w2_ff[e]               <= port.ww2;
            par_ff[e][`TPP_PAR_W2]  <= port.wpar[`TPP_PAR_W2];
          end
        end
      end
      assign match[e] = (tag_ff[e] == port.skey);
    end
  endgenerate

  // no multi-hit check: a corrupted tag may alias, lowest index wins
  always_comb
  begin
    port.shit = |match;
    port.sidx = '0;
    for (int i = `TPP_ENTRIES - 1; i >= 0; i--)
    begin
      if (match[i])
      begin
        port.sidx = i[`TPP_IDX_W-1:0];
      end
    end
  end

  assign port.rtag = tag_ff[port.ridx];
  assign port.rw1  = w1_ff[port.ridx];
  assign port.rw2  = w2_ff[port.ridx];
  assign port.rpar = par_ff[port.ridx];
endmodule

/* File: src/tpp_top.sv */
// tlb parity protection: register slave, command execution and machine-check flow
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`include "tpp_consts.svh"
module tpp_top
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             mc_take,
  output logic             insn_flush,
  output logic             refill_valid
);
  // ==========================================================
  // declarations
  tpp_pkg::tpp_bus_e       bus_ff;
  tpp_pkg::tpp_bus_e       nxt_bus;
  tpp_pkg::tpp_op_e        op;
  logic [7:0]              dp_addr_ff;
  logic                    wr_pend_ff;
  logic [31:0]             hrdata_ff;
  logic [31:0]             nxt_hrdata;
  logic [31:0]             core_config_reg_a_ff;
  logic [31:0]             core_config_reg_b_ff;
  logic [31:0]             machine_state_reg_ff;
  logic [31:0]             machine_check_status_reg_ff;
  logic [31:0]             check_save_address_reg_ff;
  logic [31:0]             check_save_state_reg_ff;
  logic [31:0]             pc_ff;
  logic [31:0]             gpr_ff;
  logic [31:0]             destination_gpr_ff;
  logic [31:0]             status_ff;
  logic                    mc_take_ff;
  logic                    insn_flush_ff;
  logic                    refill_valid_ff;
  logic                    accept;
  logic                    cmd_go;
  logic [1:0]              word_select_field;
  logic [`TPP_IDX_W-1:0]   cmd_idx;
  logic [7:0]              cmd_tid;
  logic [3:0]              parity_error_inject_field;
  logic                    parity_readout_enable;
  logic                    recovery_enable;
  logic                    machine_check_enable;
  logic [`TPP_PAR_W-1:0]   gen_par;
  logic [`TPP_PAR_W-1:0]   chk_par;
  logic [`TPP_PAR_W-1:0]   err_vec;
  logic                    tag_err;
  logic                    w1_err;
  logic                    w2_err;
  logic                    perr;
  logic                    is_refill;
  logic                    take;
  logic                    flush;
  logic                    dest_upd;
  logic [31:0]             rd_word;
  logic [1:0]              tag_parity_field;
  logic [3:0]              tag_par4;
  logic [1:0]              word1_parity_field;
  logic [1:0]              word2_parity_field;
  logic [31:0]             machine_check_status_reg_set;
  logic [31:0]             machine_check_status_reg_clr;

  tpp_tlb_if tlb ();

  // ==========================================================
  // ahb-lite slave
  // reads take one wait state so read data always comes from a flop
  assign accept = hsel && htrans[1] && hready;

  always_comb
  begin
    nxt_bus = tpp_pkg::TPP_BUS_IDLE;
    unique case (bus_ff)
      tpp_pkg::TPP_BUS_IDLE,
      tpp_pkg::TPP_BUS_RDOUT:
      begin
        if (accept && !hwrite)
        begin
          nxt_bus = tpp_pkg::TPP_BUS_RDCAP;
        end
      end
      tpp_pkg::TPP_BUS_RDCAP:
      begin
        nxt_bus = tpp_pkg::TPP_BUS_RDOUT;
      end
      default:
      begin
        nxt_bus = tpp_pkg::TPP_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_ff <= tpp_pkg::TPP_BUS_IDLE;
    end
    else
    begin
      bus_ff <= nxt_bus;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_addr_ff <= '0;
      wr_pend_ff <= 1'b0;
    end
    else
    begin
      wr_pend_ff <= accept && hwrite;
      if (accept)
      begin
        dp_addr_ff <= haddr[7:0];
      end
    end
  end

  always_comb
  begin
    nxt_hrdata = `TPP_ZERO32;
    unique case (dp_addr_ff)
      `TPP_OFF_CFGA: nxt_hrdata = core_config_reg_a_ff;
      `TPP_OFF_CFGB: nxt_hrdata = core_config_reg_b_ff;
      `TPP_OFF_MSR:  nxt_hrdata = machine_state_reg_ff;
      `TPP_OFF_MACHINE_CHECK_STATUS_REG: nxt_hrdata = machine_check_status_reg_ff;
      `TPP_OFF_SAV0: nxt_hrdata = check_save_address_reg_ff;
      `TPP_OFF_SAV1: nxt_hrdata = check_save_state_reg_ff;
      `TPP_OFF_PC:   nxt_hrdata = pc_ff;
      `TPP_OFF_GPR:  nxt_hrdata = gpr_ff;
      `TPP_OFF_DEST: nxt_hrdata = destination_gpr_ff;
      `TPP_OFF_STAT: nxt_hrdata = status_ff;
      default:       nxt_hrdata = `TPP_ZERO32;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_ff <= `TPP_ZERO32;
    end
    else if (bus_ff == tpp_pkg::TPP_BUS_RDCAP)
    begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = (bus_ff != tpp_pkg::TPP_BUS_RDCAP);
  assign hresp     = 1'b0;

  // ==========================================================
  // plain software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_config_reg_a_ff <= `TPP_ZERO32;
      core_config_reg_b_ff <= `TPP_ZERO32;
      pc_ff                <= `TPP_ZERO32;
      gpr_ff               <= `TPP_ZERO32;
    end
    else if (wr_pend_ff)
    begin
      if (dp_addr_ff == `TPP_OFF_CFGA)
      begin
        core_config_reg_a_ff <= hwdata;
      end
      if (dp_addr_ff == `TPP_OFF_CFGB)
      begin
        core_config_reg_b_ff <= hwdata;
      end
      if (dp_addr_ff == `TPP_OFF_PC)
      begin
        pc_ff <= hwdata;
      end
      if (dp_addr_ff == `TPP_OFF_GPR)
      begin
        gpr_ff <= hwdata;
      end
    end
  end

  assign parity_readout_enable     = core_config_reg_a_ff[`TPP_CFGA_RDPAR];
  assign recovery_enable           = core_config_reg_a_ff[`TPP_CFGA_RECOV];
  assign parity_error_inject_field = core_config_reg_b_ff[`TPP_CFGB_INJ];
  assign machine_check_enable      = machine_state_reg_ff[`TPP_MSR_ME];

  // ==========================================================
  // command decode, executed at the edge ending the command write
  assign cmd_go            = wr_pend_ff && (dp_addr_ff == `TPP_OFF_CMD);
  assign op                = tpp_pkg::tpp_op_e'(hwdata[`TPP_CMD_OP]);
  assign word_select_field = hwdata[`TPP_CMD_WS];
  assign cmd_idx           = hwdata[`TPP_CMD_IDX];
  assign cmd_tid           = hwdata[`TPP_CMD_TID];
  assign is_refill         = (op == tpp_pkg::TPP_OP_RFL_I) || (op == tpp_pkg::TPP_OP_RFL_D);

  // ==========================================================
  // array access and parity generation
  // the parity positions of the source word never reach the array
  assign tlb.we   = cmd_go && (op == tpp_pkg::TPP_OP_WRITE);
  assign tlb.wws  = word_select_field;
  assign tlb.widx = cmd_idx;
  assign tlb.wtag = {4'h0, cmd_tid, gpr_ff[`TPP_G0_HI]};
  assign tlb.ww1  = {gpr_ff[`TPP_G1_HI], gpr_ff[`TPP_G1_LO]};
  assign tlb.ww2  = gpr_ff[`TPP_G2_DAT];
  assign tlb.skey = {4'h0, cmd_tid, gpr_ff[`TPP_G0_HI]};
  assign tlb.ridx = (op == tpp_pkg::TPP_OP_SEARCH) ? tlb.sidx : cmd_idx;

  tpp_par_calc u_gen
  (
    .tag (tlb.wtag),
    .w1  (tlb.ww1),
    .w2  (tlb.ww2),
    .par (gen_par)
  );

  // inject bit n flips parity bit n of whichever word is written
  assign tlb.wpar = {gen_par[`TPP_PAR_TAG] ^ parity_error_inject_field,
                     gen_par[`TPP_PAR_W1] ^ parity_error_inject_field[1:0],
                     gen_par[`TPP_PAR_W2] ^ parity_error_inject_field[1:0]};

  tpp_tlb_mem u_mem
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .port    (tlb.mem)
  );

  // ==========================================================
  // parity check
  tpp_par_calc u_chk
  (
    .tag (tlb.rtag),
    .w1  (tlb.rw1),
    .w2  (tlb.rw2),
    .par (chk_par)
  );

  assign err_vec = chk_par ^ tlb.rpar;
  assign tag_err = |err_vec[`TPP_PAR_TAG];
  assign w1_err  = |err_vec[`TPP_PAR_W1];
  assign w2_err  = |err_vec[`TPP_PAR_W2];

  always_comb
  begin
    perr = 1'b0;
    unique case (op)
      tpp_pkg::TPP_OP_READ:
      begin
        if (word_select_field == `TPP_WS0)
        begin
          perr = tag_err;
        end
        else if (word_select_field == `TPP_WS1)
        begin
          perr = w1_err;
        end
        else if (word_select_field == `TPP_WS2)
        begin
          perr = w2_err;
        end
      end
      tpp_pkg::TPP_OP_SEARCH:
      begin
        perr = tlb.shit && tag_err;
      end
      tpp_pkg::TPP_OP_RFL_I,
      tpp_pkg::TPP_OP_RFL_D:
      begin
        perr = tag_err || w1_err || w2_err;
      end
      default:
      begin
        perr = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // read result, parity shown only when readout is enabled
  assign tag_par4           = parity_readout_enable ? tlb.rpar[`TPP_PAR_TAG] : 4'h0;
  assign word1_parity_field = parity_readout_enable ? tlb.rpar[`TPP_PAR_W1] : 2'h0;
  assign word2_parity_field = parity_readout_enable ? tlb.rpar[`TPP_PAR_W2] : 2'h0;
  assign tag_parity_field   = tag_par4[1:0];

  always_comb
  begin
    rd_word = `TPP_ZERO32;
    if (word_select_field == `TPP_WS0)
    begin
      rd_word = {tlb.rtag[27:0], tag_par4[3:2], tag_parity_field};
    end
    else if (word_select_field == `TPP_WS1)
    begin
      rd_word = {tlb.rw1[25:4], word1_parity_field, 4'h0, tlb.rw1[3:0]};
    end
    else if (word_select_field == `TPP_WS2)
    begin
      rd_word = {14'h0, word2_parity_field, 1'b0, tlb.rw2};
    end
  end

  // ==========================================================
  // machine-check flow
  // without recovery enable the check lands after the read completes
  assign take     = cmd_go && perr && machine_check_enable;
  assign flush    = (take && !(op == tpp_pkg::TPP_OP_READ && !recovery_enable))
                  || (cmd_go && is_refill && perr);
  assign dest_upd = cmd_go && (op == tpp_pkg::TPP_OP_READ) && !(take && recovery_enable);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      destination_gpr_ff <= `TPP_ZERO32;
    end
    else if (dest_upd)
    begin
      destination_gpr_ff <= rd_word;
    end
    else if (cmd_go && op == tpp_pkg::TPP_OP_SEARCH && tlb.shit && !take)
    begin
      destination_gpr_ff <= {26'h0, tlb.sidx};
    end
  end

  // status flags: hardware set beats a same-cycle software clear
  always_comb
  begin
    machine_check_status_reg_set = `TPP_ZERO32;
    machine_check_status_reg_clr = `TPP_ZERO32;
    if (cmd_go && perr)
    begin
      machine_check_status_reg_set[`TPP_MACHINE_CHECK_STATUS_REG_TRANSLATION_PARITY_ERROR_FLAG] = 1'b1;
      machine_check_status_reg_set[`TPP_MACHINE_CHECK_STATUS_REG_MCS]  = 1'b1;
      machine_check_status_reg_set[`TPP_MACHINE_CHECK_STATUS_REG_IMPRECISE_CHECK_FLAG] = !machine_check_enable;
    end
    if (wr_pend_ff && dp_addr_ff == `TPP_OFF_MACHINE_CHECK_STATUS_REG)
    begin
      machine_check_status_reg_clr = hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      machine_check_status_reg_ff <= `TPP_ZERO32;
    end
    else
    begin
      machine_check_status_reg_ff <= (machine_check_status_reg_ff & ~machine_check_status_reg_clr) | machine_check_status_reg_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      machine_state_reg_ff <= `TPP_ZERO32;
    end
    else if (take)
    begin
      machine_state_reg_ff[`TPP_MSR_ME] <= 1'b0;
    end
    else if (wr_pend_ff && dp_addr_ff == `TPP_OFF_MSR)
    begin
      machine_state_reg_ff <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      check_save_address_reg_ff <= `TPP_ZERO32;
      check_save_state_reg_ff   <= `TPP_ZERO32;
    end
    else if (take)
    begin
      check_save_address_reg_ff <= pc_ff;
      check_save_state_reg_ff   <= machine_state_reg_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_ff       <= `TPP_ZERO32;
      mc_take_ff      <= 1'b0;
      insn_flush_ff   <= 1'b0;
      refill_valid_ff <= 1'b0;
    end
    else
    begin
      mc_take_ff      <= take;
      insn_flush_ff   <= flush;
      refill_valid_ff <= cmd_go && is_refill && !perr;
      if (cmd_go)
      begin
        status_ff                <= `TPP_ZERO32;
        status_ff[`TPP_ST_DONE]  <= !flush;
        status_ff[`TPP_ST_FLUSH] <= flush;
        status_ff[`TPP_ST_HIT]   <= tlb.shit;
        status_ff[`TPP_ST_TAKEN] <= take;
      end
    end
  end

  assign mc_take      = mc_take_ff;
  assign insn_flush   = insn_flush_ff;
  assign refill_valid = refill_valid_ff;
endmodule

/* File: verification/tpp_top_assertions.sv */
// concurrent checks on the ports of the tlb parity protection top
`timescale 1ns/1ns
`include "tpp_consts.svh"
module tpp_top_assertions
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        mc_take,
  input wire logic        insn_flush,
  input wire logic        refill_valid
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================
  // transfer decode
  logic rd_t;
  logic wr_t;
  logic cmd_t;
  assign rd_t  = hsel && htrans[1] && hready && !hwrite;
  assign wr_t  = hsel && htrans[1] && hready && hwrite;
  assign cmd_t = wr_t && (haddr[7:0] == `TPP_OFF_CMD);
  // ==========================================
  // properties
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp left OKAY");
  write_nowait_a: assert property (wr_t |=> hreadyout)
    else $error("write data phase stalled");
  read_wait_a: assert property (rd_t |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  rdata_hold_a: assert property (!$past(rd_t, 2) |-> $stable(hrdata))
    else $error("hrdata changed without a read");
  check_pulse_a: assert property (mc_take |=> !mc_take)
    else $error("machine check pulse too long");
  flush_pulse_a: assert property (insn_flush |=> !insn_flush)
    else $error("flush pulse too long");
  refill_clean_a: assert property (refill_valid |-> !insn_flush && !mc_take)
    else $error("refill completed beside an error");
  check_cause_a: assert property (mc_take |-> $past(cmd_t, 2) || $past(cmd_t, 3))
    else $error("machine check without a command");
  refill_cause_a: assert property (refill_valid |-> $past(cmd_t, 2) || $past(cmd_t, 3))
    else $error("refill pulse without a command");
endmodule
bind tpp_top tpp_top_assertions u_assert
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .mc_take(mc_take), .insn_flush(insn_flush), .refill_valid(refill_valid)
);

/* File: verification/tpp_top_tb.sv */
// self-checking bench for the tlb parity protection top
`timescale 1ns/1ns
module tpp_top_tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} tpp_row_s;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        mc_take;
  logic        insn_flush;
  logic        refill_valid;
  logic [7:0]  n_mc = 8'h0;
  logic [7:0]  n_fl = 8'h0;
  logic [7:0]  n_rv = 8'h0;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;
  tpp_top dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mc_take(mc_take),
    .insn_flush(insn_flush), .refill_valid(refill_valid)
  );
  always #20 hclk = ~hclk;
  // ==========================================
  // pulse counting and hang guard
  always @(posedge hclk)
  begin
    if (mc_take === 1'b1) n_mc <= n_mc + 8'h1;
    if (insn_flush === 1'b1) n_fl <= n_fl + 8'h1;
    if (refill_valid === 1'b1) n_rv <= n_rv + 8'h1;
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares++;
      finish_test();
    end
  end
  // ==========================================
  // bus and compare tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask
  // pulses expected as {check taken, flushed, refill done}
  // counters belong to the pulse process alone; a command looks at how far they moved
  task automatic cmd(input logic [31:0] c, input logic [2:0] e);
    logic [7:0] m0;
    logic [7:0] f0;
    logic [7:0] r0;
    m0 = n_mc;
    f0 = n_fl;
    r0 = n_rv;
    wr(8'h20, c);
    repeat (3) @(posedge hclk);
    chk({8'h0, 8'(n_mc - m0), 8'(n_fl - f0), 8'(n_rv - r0)}, {15'h0, e[2], 7'h0, e[1], 7'h0, e[0]});
  endtask
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // ordinary cases: write, read back, search, no-op
  tpp_row_s rows [27] = '{
    '{1'b0, 8'h08, 32'h0}, '{1'b0, 8'h0C, 32'h0}, '{1'b1, 8'h00, 32'h1}, '{1'b1, 8'h1C, 32'h1F},
    '{1'b1, 8'h20, 32'h501}, '{1'b1, 8'h20, 32'h502}, '{1'b0, 8'h24, 32'h11},
    '{1'b1, 8'h1C, 32'hF01}, '{1'b1, 8'h20, 32'h511}, '{1'b1, 8'h20, 32'h512}, '{1'b0, 8'h24, 32'hD01},
    '{1'b1, 8'h1C, 32'h20101}, '{1'b1, 8'h20, 32'h521}, '{1'b1, 8'h20, 32'h522}, '{1'b0, 8'h24, 32'h30101},
    '{1'b1, 8'h00, 32'h0}, '{1'b1, 8'h20, 32'h502}, '{1'b0, 8'h24, 32'h10},
    '{1'b1, 8'h1C, 32'h10}, '{1'b1, 8'h20, 32'h503}, '{1'b0, 8'h24, 32'h5}, '{1'b0, 8'h28, 32'h5},
    '{1'b1, 8'h20, 32'h500}, '{1'b0, 8'h24, 32'h5}, '{1'b0, 8'h0C, 32'h0},
    '{1'b0, 8'h30, 32'h0}, '{1'b0, 8'h20, 32'h0}};
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd_chk(rows[i].a, rows[i].d);
    // inject a tag parity flip into entry 7, then read it with recovery on
    wr(8'h04, 32'h1);
    wr(8'h1C, 32'h2F);
    cmd(32'h701, 3'h0);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h3);
    wr(8'h18, 32'h1234);
    cmd(32'h702, 3'h6);
    rd_chk(8'h0C, 32'h3);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h10, 32'h1234);
    rd_chk(8'h14, 32'h1);
    rd_chk(8'h24, 32'h5);
    // check enable clear: the read completes and shows the flipped parity
    wr(8'h0C, 32'h7);
    cmd(32'h702, 3'h0);
    rd_chk(8'h0C, 32'h7);
    rd_chk(8'h24, 32'h20);
    // search lands on the corrupt tag
    wr(8'h0C, 32'h7);
    wr(8'h08, 32'h1);
    wr(8'h1C, 32'h20);
    cmd(32'h3, 3'h6);
    rd_chk(8'h24, 32'h20);
    // shadow refills: corrupt tag, clean entry, corrupt word 2
    wr(8'h0C, 32'h7);
    cmd(32'h704, 3'h2);
    rd_chk(8'h0C, 32'h7);
    cmd(32'h505, 3'h1);
    wr(8'h04, 32'h1);
    wr(8'h1C, 32'h0);
    cmd(32'h621, 3'h0);
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h7);
    cmd(32'h602, 3'h0);
    rd_chk(8'h0C, 32'h0);
    cmd(32'h604, 3'h2);
    rd_chk(8'h0C, 32'h7);
    // reset in mid-run clears flags and controls
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(8'h0C, 32'h0);
    rd_chk(8'h08, 32'h0);
    finish_test();
  end
endmodule
